/* core/bdrs_ctrl.sv */
/*
  Bidirectional reset controller: sequences internal resets from the reset
  pin, software and watchdog, drives the open-drain reset pin, latches the
  startup port and reports the reset source over a Wishbone classic slave.
  Assumes all inputs synchronous to i_clk and an external open-drain pull-up.
*/
// The Wishbone register port and the address map were decided locally.
// Summary of operation
// [R1] Enable bit locked after end of initialization
// [R2] Any reset clears the enable bit
// [R3] Bidirectional mode reports long hardware reset
// [R4] Latch startup port after pin resets or bidirectional-mode resets; bit4 low selects bootstrap
// [R5] Short pin reset stretched to full sequence in bidirectional mode
// [R6] Drive pin low during sequence, then release; code drives it only in bidirectional mode
`timescale 1ns/100ps
module bdrs_ctrl
(
  input  wire logic                        i_clk,            // System clock, 50 MHz
  input  wire logic                        i_rst,            // Async reset, active high
  input  wire logic                        i_wb_cyc,         // Wishbone cycle
  input  wire logic                        i_wb_stb,         // Wishbone strobe
  input  wire logic                        i_wb_we,          // Wishbone write enable
  input  wire logic [bdrs_pkg::ADR_W-1:0]  i_wb_adr,         // Wishbone byte address
  input  wire logic [3:0]                  i_wb_sel,         // Wishbone byte selects
  input  wire logic [31:0]                 i_wb_dat,         // Wishbone write data
  output logic      [31:0]                 o_wb_dat,         // Wishbone read data
  output logic                             o_wb_ack,         // Wishbone acknowledge
  input  wire logic                        i_rst_pin_in,     // Reset input pin level
  output logic                             o_rst_pin_out,    // Reset pin drive value
  output logic                             o_rst_pin_oe,     // Reset pin output enable
  input  wire logic                        i_wdt_reset,      // Watchdog reset request
  input  wire logic [7:0]                  i_startup_config_port_low_byte, // Startup config port
  output logic      [7:0]                  o_startup_cfg,    // Latched startup config
  output logic                             o_bootstrap,      // Bootstrap loader select
  output logic                             o_sys_rst         // Internal reset active
);

  bdrs_pkg::bdrs_state_e       state_reg;
  bdrs_pkg::bdrs_state_e       state_next;
  logic [bdrs_pkg::CNT_W-1:0]  count;
  logic                        ack_reg;
  logic [31:0]                 rdat_reg;
  logic                        bidir_reset_enable_reg;
  logic                        init_done_reg;
  logic                        bdr_act_reg;
  logic [3:0]                  src_reg;
  logic                        long_seen_reg;
  logic [3:0]                  flags_reg;
  logic [7:0]                  cfg_reg;
  logic                        boot_reg;
  logic                        pin_low;
  logic                        wb_req;
  logic                        wr;
  logic                        wr_ctrl;
  logic                        wr_cmd;
  logic                        sw_req;
  logic                        end_of_init_instruction;
  logic                        start;
  logic                        finish;
  logic                        cnt_run;

  assign pin_low = ~i_rst_pin_in;
  assign wb_req  = i_wb_cyc & i_wb_stb & ~ack_reg;
  assign wr      = wb_req & i_wb_we & i_wb_sel[0];
  assign wr_ctrl = wr & (i_wb_adr == bdrs_pkg::OFF_CTRL);
  assign wr_cmd  = wr & (i_wb_adr == bdrs_pkg::OFF_CMD);
  assign sw_req  = wr_cmd & i_wb_dat[bdrs_pkg::CMD_SOFT_BIT];
  assign end_of_init_instruction = wr_cmd & i_wb_dat[bdrs_pkg::CMD_INIT_END_BIT];

  assign start   = (state_reg == bdrs_pkg::ST_IDLE) & (pin_low | sw_req | i_wdt_reset);
  assign finish  = ((state_reg == bdrs_pkg::ST_PIN_LOW) | (state_reg == bdrs_pkg::ST_RELEASE))
                   & ~pin_low;
  assign cnt_run = (state_reg == bdrs_pkg::ST_PIN_LOW) | (state_reg == bdrs_pkg::ST_SEQ);

  bdrs_cycle_counter bdrs_cycle_counter_i
  (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_run   (cnt_run),
    .o_count (count)
  );

  // Sequencer
  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      bdrs_pkg::ST_IDLE:
        if (start)
        begin
          if (bidir_reset_enable_reg | ~pin_low)
            state_next = bdrs_pkg::ST_SEQ;      // [R5]
          else
            state_next = bdrs_pkg::ST_PIN_LOW;
        end
      bdrs_pkg::ST_PIN_LOW:
        if (!pin_low)
          state_next = bdrs_pkg::ST_IDLE;
      bdrs_pkg::ST_SEQ:
        if (count == bdrs_pkg::SEQ_LAST)
          state_next = bdrs_pkg::ST_RELEASE;    // [R5]
      bdrs_pkg::ST_RELEASE:
        if (!pin_low)
          state_next = bdrs_pkg::ST_IDLE;
      default:
        state_next = bdrs_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      state_reg <= bdrs_pkg::ST_IDLE;
    else
      state_reg <= state_next;
  end

  // Reset context captured at entry
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      bdr_act_reg <= 1'b0;
      src_reg     <= bdrs_pkg::FLAGS_RESET;
    end
    else if (start)
    begin
      bdr_act_reg <= bidir_reset_enable_reg;
      if (pin_low)
        src_reg <= bdrs_pkg::FLAG_LONG;
      else if (i_wdt_reset)
        src_reg <= bdrs_pkg::FLAG_WDT;
      else
        src_reg <= bdrs_pkg::FLAG_SOFT;
    end
  end

  // Pin hold length
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      long_seen_reg <= 1'b0;
    else if (start)
      long_seen_reg <= 1'b0;
    else if ((state_reg == bdrs_pkg::ST_PIN_LOW) && (count >= bdrs_pkg::LONG_LAST))
      long_seen_reg <= 1'b1;
  end

  // Reset-source flags
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      flags_reg <= bdrs_pkg::FLAG_LONG;
    else if (finish)
    begin
      if (bdr_act_reg)
        flags_reg <= bdrs_pkg::FLAG_LONG;       // [R3]
      else if (src_reg == bdrs_pkg::FLAG_LONG)
        flags_reg <= long_seen_reg ? bdrs_pkg::FLAG_LONG : bdrs_pkg::FLAG_SHORT;
      else
        flags_reg <= src_reg;
    end
  end

  // Startup configuration latch
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      cfg_reg  <= bdrs_pkg::CFG_RESET;
      boot_reg <= 1'b0;
    end
    else if (finish && (bdr_act_reg || (src_reg == bdrs_pkg::FLAG_LONG)))
    begin
      cfg_reg  <= i_startup_config_port_low_byte;                                   // [R4]
      boot_reg <= ~i_startup_config_port_low_byte[bdrs_pkg::BOOT_SEL_BIT];          // [R4]
    end
  end

  // Enable bit and initialization lock
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      bidir_reset_enable_reg <= 1'b0;
    else if (start)
      bidir_reset_enable_reg <= 1'b0;                                 // [R2]
    else if (wr_ctrl && !init_done_reg)
      bidir_reset_enable_reg <= i_wb_dat[bdrs_pkg::CTRL_BDR_BIT];     // [R1]
  end

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      init_done_reg <= 1'b0;
    else if (start)
      init_done_reg <= 1'b0;
    else if (end_of_init_instruction)
      init_done_reg <= 1'b1;
  end

  // Wishbone slave, one wait-state registered answer
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      ack_reg  <= 1'b0;
      rdat_reg <= '0;
    end
    else
    begin
      ack_reg <= wb_req;
      if (wb_req)
      begin
        rdat_reg <= '0;
        unique case (i_wb_adr)
          bdrs_pkg::OFF_CTRL:
            rdat_reg[bdrs_pkg::CTRL_BDR_BIT] <= bidir_reset_enable_reg;
          bdrs_pkg::OFF_STATUS:
          begin
            rdat_reg[bdrs_pkg::ST_WDT_BIT:bdrs_pkg::ST_SHORT_BIT] <= flags_reg;
            rdat_reg[bdrs_pkg::ST_INIT_BIT] <= init_done_reg;
            rdat_reg[bdrs_pkg::ST_BOOT_BIT] <= boot_reg;
            rdat_reg[bdrs_pkg::ST_BDR_BIT]  <= bidir_reset_enable_reg;
          end
          bdrs_pkg::OFF_CONFIG:
            rdat_reg[7:0] <= cfg_reg;
          default:
            rdat_reg <= '0;
        endcase
      end
    end
  end

  assign o_wb_ack      = ack_reg;
  assign o_wb_dat      = rdat_reg;
  assign o_rst_pin_out = 1'b0;
  assign o_rst_pin_oe  = (state_reg == bdrs_pkg::ST_SEQ) & bdr_act_reg;   // [R6]
  assign o_sys_rst     = (state_reg != bdrs_pkg::ST_IDLE);
  assign o_startup_cfg = cfg_reg;
  assign o_bootstrap   = boot_reg;

  // Checks
  sequence s_locked_write;
    init_done_reg && wr_ctrl && !start;
  endsequence

  property p_enable_locked;
    @(posedge i_clk) disable iff (i_rst)
    s_locked_write |=> $stable(bidir_reset_enable_reg);
  endproperty
  a_enable_locked: assert property (p_enable_locked)  // [R1]
    else $error("enable bit changed after end of initialization");

  property p_enable_cleared;
    @(posedge i_clk) disable iff (i_rst)
    start |=> !bidir_reset_enable_reg && !init_done_reg;
  endproperty
  a_enable_cleared: assert property (p_enable_cleared)  // [R2]
    else $error("enable bit not cleared by reset");

  property p_long_flag;
    @(posedge i_clk) disable iff (i_rst)
    finish && bdr_act_reg |=> flags_reg == bdrs_pkg::FLAG_LONG;
  endproperty
  a_long_flag: assert property (p_long_flag)  // [R3]
    else $error("bidirectional reset did not report long hardware reset");

  property p_cfg_latch;
    @(posedge i_clk) disable iff (i_rst)
    finish && bdr_act_reg |=> (cfg_reg == $past(i_startup_config_port_low_byte))
      && (boot_reg == !$past(i_startup_config_port_low_byte[bdrs_pkg::BOOT_SEL_BIT]));
  endproperty
  a_cfg_latch: assert property (p_cfg_latch)  // [R4]
    else $error("startup configuration not latched");

  sequence s_seq_enter;
    (state_reg == bdrs_pkg::ST_IDLE) && start && bidir_reset_enable_reg;
  endsequence

  property p_stretch;
    @(posedge i_clk) disable iff (i_rst)
    s_seq_enter |=> (state_reg == bdrs_pkg::ST_SEQ) [*8] ##0 o_sys_rst;
  endproperty
  a_stretch: assert property (p_stretch)  // [R5]
    else $error("short reset not stretched");

  property p_seq_length;
    @(posedge i_clk) disable iff (i_rst)
    (state_reg == bdrs_pkg::ST_SEQ) && (count < bdrs_pkg::SEQ_LAST)
      |=> state_reg == bdrs_pkg::ST_SEQ;
  endproperty
  a_seq_length: assert property (p_seq_length)  // [R5]
    else $error("reset sequence ended early");

  sequence s_drive;
    o_rst_pin_oe && !o_rst_pin_out;
  endsequence

  property p_pin_drive;
    @(posedge i_clk) disable iff (i_rst)
    (state_reg == bdrs_pkg::ST_SEQ) && bdr_act_reg && (count == bdrs_pkg::SEQ_LAST)
      |-> s_drive ##1 !o_rst_pin_oe;
  endproperty
  a_pin_drive: assert property (p_pin_drive)  // [R6]
    else $error("reset pin not driven then released");

endmodule : bdrs_ctrl

/* pkg/bdrs_pkg.sv */
/*
  Constants for the bidirectional reset controller: register map, field
  positions, timing figures and the sequencer state encoding.
  Assumes a 50 MHz system clock.
*/
package bdrs_pkg;

  // Register byte offsets
  localparam logic [3:0] OFF_CTRL   = 4'h0;
  localparam logic [3:0] OFF_CMD    = 4'h4;
  localparam logic [3:0] OFF_STATUS = 4'h8;
  localparam logic [3:0] OFF_CONFIG = 4'hC;
  localparam int         ADR_W      = 4;

  // CTRL fields
  localparam int CTRL_BDR_BIT   = 0;
  // CMD fields
  localparam int CMD_INIT_END_BIT = 0;
  localparam int CMD_SOFT_BIT   = 1;
  // STATUS fields
  localparam int ST_SHORT_BIT   = 0;
  localparam int ST_LONG_BIT    = 1;
  localparam int ST_SOFT_BIT    = 2;
  localparam int ST_WDT_BIT     = 3;
  localparam int ST_INIT_BIT    = 4;
  localparam int ST_BOOT_BIT    = 5;
  localparam int ST_BDR_BIT     = 6;

  // Reset-source flags
  localparam logic [3:0] FLAGS_RESET = 4'h0;
  localparam logic [3:0] FLAG_SHORT  = 4'h1;
  localparam logic [3:0] FLAG_LONG   = 4'h2;
  localparam logic [3:0] FLAG_SOFT   = 4'h4;
  localparam logic [3:0] FLAG_WDT    = 4'h8;

  // Startup port: bit that selects the bootstrap loader when low
  localparam int         BOOT_SEL_BIT = 4;
  localparam logic [7:0] CFG_RESET    = 8'hFF;

  // Timing
  localparam int CLK_PERIOD_NS = 20;
  localparam int SEQ_TIME_NS   = 20480;
  localparam int LONG_TIME_NS  = 1280;
  localparam int SEQ_CYCLES    = (SEQ_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LONG_CYCLES   = (LONG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W         = 11;
  localparam logic [CNT_W-1:0] SEQ_LAST  = CNT_W'(SEQ_CYCLES - 1);
  localparam logic [CNT_W-1:0] LONG_LAST = CNT_W'(LONG_CYCLES - 1);

  // Sequencer states
  typedef enum logic [3:0] {
    ST_IDLE    = 4'h1,
    ST_PIN_LOW = 4'h2,
    ST_SEQ     = 4'h4,
    ST_RELEASE = 4'h8
  } bdrs_state_e;

endpackage : bdrs_pkg

/* core/bdrs_cycle_counter.sv */
/*
  Saturating cycle counter used to time the internal reset sequence and
  to measure how long the reset pin is held low.
  Assumes a synchronous run input; count returns to zero when run is low.
*/
`timescale 1ns/100ps
module bdrs_cycle_counter
(
  input  wire logic                      i_clk,   // System clock
  input  wire logic                      i_rst,   // Async reset, active high
  input  wire logic                      i_run,   // Count while high
  output logic [bdrs_pkg::CNT_W-1:0]     o_count  // Cycles counted so far
);

  logic [bdrs_pkg::CNT_W-1:0] count_reg;

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      count_reg <= '0;
    else if (!i_run)
      count_reg <= '0;
    else if (count_reg != '1)
      count_reg <= count_reg + 1'b1;
  end

  assign o_count = count_reg;

endmodule : bdrs_cycle_counter

/* tb/bdrs_ext_src.sv */
/*
  External reset source: open-drain pull on the reset pin for a set count.
  Assumes a pull-up on the pin; released means the pin goes high.
*/
`timescale 1ns/100ps
module bdrs_ext_src
(
  input  wire logic       i_clk,      // System clock
  input  wire logic       i_rst,      // Async reset, active high
  input  wire logic       i_go,       // Start a low pulse
  input  wire logic [7:0] i_len,      // Pulse length in cycles
  output logic            o_pull_low  // Pulls the pin low
);
  logic [7:0] left_reg;

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      left_reg <= 8'h00;
    else if (i_go)
      left_reg <= i_len;
    else if (left_reg != 8'h00)
      left_reg <= left_reg - 8'h01;
  end

  assign o_pull_low = (left_reg != 8'h00);
endmodule : bdrs_ext_src

/* tb/bdrs_ctrl_bench.sv */
/*
  Self-checking bench for the bidirectional reset controller.
  Assumes the reset pin has a pull-up and both drivers are open drain.
*/
`timescale 1ns/100ps
module bdrs_ctrl_bench;
  logic clk, rst, cyc, stb, we, wdt, go, pull, oe, pout, sys, boot, pin, ack;
  logic [3:0]  adr, sel;
  logic [31:0] wdat, rdat, q;
  logic [7:0]  port, cfg, len;
  int mismatches, n_checks;

  // Wire-AND of both open-drain drivers with the pull-up
  assign pin = !((oe && !pout) || pull);

  bdrs_ctrl bdrs_ctrl_i (.i_clk(clk), .i_rst(rst), .i_wb_cyc(cyc), .i_wb_stb(stb),
    .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(rdat),
    .o_wb_ack(ack), .i_rst_pin_in(pin), .o_rst_pin_out(pout), .o_rst_pin_oe(oe),
    .i_wdt_reset(wdt), .i_startup_config_port_low_byte(port), .o_startup_cfg(cfg),
    .o_bootstrap(boot), .o_sys_rst(sys));
  bdrs_ext_src bdrs_ext_src_i (.i_clk(clk), .i_rst(rst), .i_go(go), .i_len(len),
    .o_pull_low(pull));

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : tally_and_finish

  task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : check_word

  task automatic check_flag(input logic got, input logic exp);
    check_word({31'h0, got}, {31'h0, exp});
  endtask : check_flag

  // Classic single cycle; waits for ack under a bound
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d; sel <= 4'hF;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (ack !== 1'b1 && n < 50);
    if (n >= 50)
      check_flag(1'b0, 1'b1);
    q = rdat;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
  endtask : wb

  task automatic reset_values;
    wb(0, bdrs_pkg::OFF_STATUS, 0); check_word(q, 32'h02);
    wb(0, bdrs_pkg::OFF_CONFIG, 0); check_word(q, 32'hFF);
    wb(0, 4'h2, 0); check_word(q, 32'h0);
    check_flag(boot, 1'b0);
  endtask : reset_values

  task automatic lock_check;
    wb(1, bdrs_pkg::OFF_CTRL, 1);
    wb(0, bdrs_pkg::OFF_STATUS, 0); check_word(q & 32'h50, 32'h40);
    wb(1, bdrs_pkg::OFF_CMD, 1);
    wb(1, bdrs_pkg::OFF_CTRL, 0);
    wb(0, bdrs_pkg::OFF_STATUS, 0); check_word(q & 32'h50, 32'h50);
  endtask : lock_check

  // kind 0 pin pulse, 1 watchdog, 2 software
  task automatic run_reset(input int kind, input logic en, input logic [7:0] p,
                           input logic [31:0] exp_st, input logic [7:0] exp_cfg);
    int n, oe_n, sys_n;
    n = 0; oe_n = 0; sys_n = 0;
    if (en)
      wb(1, bdrs_pkg::OFF_CTRL, 1);
    @(posedge clk);
    port <= p;
    if (kind == 2)
      wb(1, bdrs_pkg::OFF_CMD, 2);
    else
    begin
      @(posedge clk);
      go <= (kind == 0); wdt <= (kind == 1);
      @(posedge clk);
      go <= 1'b0; wdt <= 1'b0;
    end
    while (sys !== 1'b1 && n < 20)
    begin
      @(posedge clk);
      n++;
    end
    do
    begin
      if (oe === 1'b1)
        oe_n++;
      sys_n++;
      @(posedge clk);
    end
    while (sys === 1'b1 && sys_n < 3000);
    check_word(oe_n, en ? bdrs_pkg::SEQ_CYCLES : 0);
    check_flag(sys_n >= bdrs_pkg::SEQ_CYCLES, en || kind != 0);
    check_flag(oe, 1'b0);
    check_flag(pout, 1'b0);
    wb(0, bdrs_pkg::OFF_STATUS, 0); check_word(q, exp_st);
    wb(0, bdrs_pkg::OFF_CONFIG, 0); check_word(q, {24'h0, exp_cfg});
    check_flag(boot, exp_st[5]);
    check_word({24'h0, cfg}, {24'h0, exp_cfg});
  endtask : run_reset

  // Disabled pin reset held past the long threshold
  task automatic long_pin_reset;
    len <= 8'h50;
    run_reset(0, 1'b0, 8'hEF, 32'h22, 8'hEF);
    len <= 8'h05;
  endtask : long_pin_reset

  // Mid-run hard reset drops the enable bit and the latched startup state
  task automatic hard_reset_clears;
    wb(1, bdrs_pkg::OFF_CTRL, 1);
    wb(0, bdrs_pkg::OFF_STATUS, 0); check_word(q, 32'h62);
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    wb(0, bdrs_pkg::OFF_STATUS, 0); check_word(q, 32'h02);
    wb(0, bdrs_pkg::OFF_CONFIG, 0); check_word(q, 32'hFF);
    check_flag(boot, 1'b0);
  endtask : hard_reset_clears

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  initial
  begin
    #400000;
    mismatches++;
    tally_and_finish();
  end

  initial
  begin
    mismatches = 0; n_checks = 0;
    rst = 1'b1; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 4'h0; sel = 4'h0;
    wdat = 32'h0; wdt = 1'b0; go = 1'b0; port = 8'hFF; len = 8'h05;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    reset_values();
    run_reset(0, 1'b0, 8'h10, 32'h01, 8'h10);
    run_reset(1, 1'b0, 8'hEF, 32'h08, 8'h10);
    long_pin_reset();
    lock_check();
    run_reset(0, 1'b1, 8'hEF, 32'h22, 8'hEF);
    run_reset(1, 1'b1, 8'hFF, 32'h02, 8'hFF);
    run_reset(2, 1'b1, 8'h6F, 32'h22, 8'h6F);
    hard_reset_clears();
    tally_and_finish();
  end
endmodule : bdrs_ctrl_bench
